/* File: rtl/tcc_timer16.sv */
`timescale 1ns/10ps
`default_nettype none
module tcc_timer16 #(
    parameter bit HAS_COMPARATOR = 1'b1, // only the first timer has it
    parameter int NC_LEN = tcc_pkg::NC_SAMPLES
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [3:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    input wire logic timer_tick_i,
    input wire logic capture_pin_i,
    input wire logic comparator_output_i,
    input wire logic comparator_sel_i,
    input wire logic capture_ack_i,
    input wire logic overflow_ack_i,
    output logic capture_irq_o,
    output logic overflow_irq_o,
    output logic top_o,
    output logic bottom_o
);
    import tcc_pkg::*;

    // refuse a filter too short to vote
    if (NC_LEN < 2) begin : g_chk
        $error("tcc_timer16: NC_LEN must be at least 2");
    end

    // whole state of the block
    typedef struct packed {
        logic [15:0] count;       // counter value
        logic [15:0] cap;         // capture value
        logic [15:0] cmpa;        // compare a
        logic [15:0] cmpb;        // compare b
        logic [7:0] temp;         // shared high-byte latch
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] irq_en;
        logic cap_flag;
        logic ovf_flag;
        tcc_dir_t dir;
        logic [1:0] sync_pin;     // pin synchroniser
        logic [1:0] sync_cmp;     // comparator synchroniser
        logic [NC_LEN-2:0] hist;  // filter history
        logic filt;               // filtered trigger level
        logic filt_prev;          // for edge detection
        logic [7:0] rdata;        // read data register
    } tcc_state_t;

    tcc_state_t s;
    tcc_state_t next_s;

    // decoded helpers, shared by next-state logic and checks
    logic [3:0] wgm;
    tcc_mode_t mode;
    logic [15:0] top;
    logic icr_top;
    logic tick;
    logic cnt_wr;
    logic capture;
    logic trig_src;
    logic [NC_LEN-1:0] window;

    // mode, top value and count enable
    always_comb begin
        wgm = {s.ctrl_b[CTRLB_WGM_LSB +: 2], s.ctrl_a[CTRLA_WGM_LSB +: 2]};
        mode = tcc_decode(wgm);
        case (mode.src)
            SRC_8: top = TOP_8BIT;
            SRC_9: top = TOP_9BIT;
            SRC_10: top = TOP_10BIT;
            SRC_CMPA: top = s.cmpa;
            SRC_CAP: top = s.cap;
            default: top = TOP_MAX;
        endcase
        icr_top = (mode.src == SRC_CAP);
        // cs zero stops; the direct setting counts every clock
        if (s.ctrl_b[CTRLB_CS_LSB +: 3] == CS_STOP) begin
            tick = 1'b0;
        end else if (s.ctrl_b[CTRLB_CS_LSB +: 3] == CS_SYSCLK) begin
            tick = 1'b1;
        end else begin
            tick = timer_tick_i;
        end
        cnt_wr = io_wr_i && (io_addr_i == ADDR_CNT_LO);
    end

    // capture trigger path: select, filter, edge detect
    always_comb begin
        // only the second synchroniser stage is looked at
        if (HAS_COMPARATOR && comparator_sel_i) begin
            trig_src = s.sync_cmp[1];
        end else begin
            trig_src = s.sync_pin[1];
        end
        window = {s.hist, trig_src};
        // capture unit is idle while capture holds the top
        if (s.ctrl_b[CTRLB_EDGE_BIT]) begin
            capture = s.filt && !s.filt_prev && !icr_top;
        end else begin
            capture = !s.filt && s.filt_prev && !icr_top;
        end
    end

    // next state
    always_comb begin
        next_s = s;
        next_s.rdata = s.rdata;
        next_s.sync_pin = {s.sync_pin[0], capture_pin_i};
        next_s.sync_cmp = {s.sync_cmp[0], comparator_output_i};
        next_s.hist = window[NC_LEN-2:0];
        next_s.filt_prev = s.filt;
        // with the NC bit set, filter moves only when all samples agree; with it clear, filter follows the input
        if (!s.ctrl_b[CTRLB_NC_BIT]) begin
            next_s.filt = trig_src;
        end else if (&window) begin
            next_s.filt = 1'b1;
        end else if (~|window) begin
            next_s.filt = 1'b0;
        end

        // overflow flag clear by write-one or ack; the count below may set
        // it again in the same cycle, so a fresh set always wins
        if ((io_wr_i && io_addr_i == ADDR_FLAGS
             && io_wdata_i[FLAG_OVF_BIT]) || overflow_ack_i) begin
            next_s.ovf_flag = 1'b0;
        end

        // counting sequence
        if (tick) begin
            if (mode.dual) begin
                // dual slope turns at top, overflows at bottom
                if (s.dir == DIR_UP) begin
                    if (s.count >= top) begin
                        next_s.dir = DIR_DOWN;
                        next_s.count = s.count - 16'h0001;
                    end else begin
                        next_s.count = s.count + 16'h0001;
                    end
                end else if (s.count == WORD_RST) begin
                    next_s.dir = DIR_UP;
                    next_s.count = s.count + 16'h0001;
                end else begin
                    next_s.count = s.count - 16'h0001;
                    if (s.count == 16'h0001) begin
                        next_s.ovf_flag = 1'b1;
                    end
                end
            end else begin
                next_s.dir = DIR_UP;
                // single slope clears at top
                if (s.count >= top) begin
                    next_s.count = WORD_RST;
                    if (mode.ovf_top || s.count == TOP_MAX) begin
                        next_s.ovf_flag = 1'b1;
                    end
                end else begin
                    next_s.count = s.count + 16'h0001;
                end
            end
        end

        // capture time stamp and flag in one cycle
        if (capture) begin
            next_s.cap = s.count;
        end

        // capture flag: set beats write-one clear and ack
        next_s.cap_flag = capture || (s.cap_flag && !capture_ack_i
            && !(io_wr_i && io_addr_i == ADDR_FLAGS
                 && io_wdata_i[FLAG_CAP_BIT]));

        // register reads; data appears the cycle after
        if (io_rd_i) begin
            case (io_addr_i)
                ADDR_CNT_LO: begin
                    next_s.rdata = s.count[7:0];
                    next_s.temp = s.count[15:8];
                end
                ADDR_CAP_LO: begin
                    next_s.rdata = s.cap[7:0];
                    next_s.temp = s.cap[15:8];
                end
                ADDR_CNT_HI, ADDR_CAP_HI: next_s.rdata = s.temp;
                ADDR_CMPA_LO: next_s.rdata = s.cmpa[7:0];
                ADDR_CMPA_HI: next_s.rdata = s.cmpa[15:8];
                ADDR_CMPB_LO: next_s.rdata = s.cmpb[7:0];
                ADDR_CMPB_HI: next_s.rdata = s.cmpb[15:8];
                ADDR_CTRL_A: next_s.rdata = s.ctrl_a;
                ADDR_CTRL_B: next_s.rdata = s.ctrl_b;
                ADDR_FLAGS: begin
                    next_s.rdata = REG_RST;
                    next_s.rdata[FLAG_CAP_BIT] = s.cap_flag;
                    next_s.rdata[FLAG_OVF_BIT] = s.ovf_flag;
                end
                ADDR_IRQ_EN: next_s.rdata = s.irq_en;
                default: next_s.rdata = REG_RST;
            endcase
        end

        // register writes; high locations only touch the latch
        if (io_wr_i) begin
            case (io_addr_i)
                ADDR_CNT_HI, ADDR_CAP_HI, ADDR_CMPA_HI,
                ADDR_CMPB_HI: next_s.temp = io_wdata_i;
                ADDR_CNT_LO: begin
                    // cpu write overrides clear and count
                    next_s.count = {s.temp, io_wdata_i};
                    next_s.dir = s.dir;
                end
                ADDR_CAP_LO: begin
                    if (icr_top) begin
                        next_s.cap = {s.temp, io_wdata_i};
                    end
                end
                ADDR_CMPA_LO: next_s.cmpa = {s.temp, io_wdata_i};
                ADDR_CMPB_LO: next_s.cmpb = {s.temp, io_wdata_i};
                ADDR_CTRL_A: next_s.ctrl_a = io_wdata_i;
                ADDR_CTRL_B: next_s.ctrl_b = io_wdata_i;
                ADDR_IRQ_EN: next_s.irq_en = io_wdata_i;
                default: next_s.ctrl_a = s.ctrl_a;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            next_s_reset();
        end else begin
            s <= next_s;
        end
    end

    // reset values, counter side and capture side
    task automatic next_s_reset();
        s.count <= WORD_RST;
        s.cap <= WORD_RST;
        s.cmpa <= WORD_RST;
        s.cmpb <= WORD_RST;
        s.temp <= REG_RST;
        s.ctrl_a <= REG_RST;
        s.ctrl_b <= REG_RST;
        s.irq_en <= REG_RST;
        s.cap_flag <= 1'b0;
        s.ovf_flag <= 1'b0;
        s.dir <= DIR_UP;
        s.sync_pin <= 2'b00;
        s.sync_cmp <= 2'b00;
        s.hist <= '0;
        s.filt <= 1'b0;
        s.filt_prev <= 1'b0;
        s.rdata <= REG_RST;
    endtask : next_s_reset

    // outputs
    assign io_rdata_o = s.rdata;
    assign capture_irq_o = s.cap_flag && s.irq_en[FLAG_CAP_BIT];
    assign overflow_irq_o = s.ovf_flag && s.irq_en[FLAG_OVF_BIT];
    assign top_o = (s.count == top);
    assign bottom_o = (s.count == WORD_RST);

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence lo_read_s;
        io_rd_i && io_addr_i == ADDR_CNT_LO && !io_wr_i;
    endsequence
    sequence hi_read_s;
        io_rd_i && io_addr_i == ADDR_CNT_HI && !io_wr_i;
    endsequence
    sequence hi_write_s;
        io_wr_i && io_addr_i == ADDR_CNT_HI;
    endsequence
    sequence lo_write_s;
        io_wr_i && io_addr_i == ADDR_CNT_LO;
    endsequence

    stop_hold_a: assert property (
        (s.ctrl_b[2:0] == CS_STOP && !cnt_wr) |=> $stable(s.count))
        else $error("counter moved with no clock selected");
    step_one_a: assert property (
        (tick && !mode.dual && s.count < top && !cnt_wr)
        |=> s.count == $past(s.count) + 16'h0001)
        else $error("up count did not step by one");
    clear_top_a: assert property (
        (tick && !mode.dual && s.count >= top && !cnt_wr)
        |=> s.count == WORD_RST)
        else $error("counter not cleared at top");
    bottom_step_a: assert property (
        (bottom_o && tick && !mode.dual && top != WORD_RST && !cnt_wr)
        |=> s.count == 16'h0001 && !bottom_o)
        else $error("bottom indication wrong");
    pair_read_a: assert property (
        lo_read_s ##1 (!io_rd_i && !io_wr_i) ##1 hi_read_s
        |=> io_rdata_o == $past(s.count[15:8], 3))
        else $error("high read did not return latched byte");
    pair_write_a: assert property (
        hi_write_s ##1 (!io_wr_i && !io_rd_i) ##1 lo_write_s
        |=> s.count == {$past(io_wdata_i, 3), $past(io_wdata_i)})
        else $error("16-bit counter write lost");
    cap_stamp_a: assert property (
        capture |=> s.cap == $past(s.count) && s.cap_flag)
        else $error("capture stamp or flag missing");
    cap_irq_a: assert property (
        (capture && s.irq_en[FLAG_CAP_BIT]) |=> capture_irq_o)
        else $error("capture interrupt not requested");
    flag_keep_a: assert property (
        (s.cap_flag && io_wr_i && io_addr_i == ADDR_FLAGS
         && !io_wdata_i[FLAG_CAP_BIT] && !capture_ack_i) |=> s.cap_flag)
        else $error("writing zero cleared capture flag");
    cap_guard_a: assert property (
        (io_wr_i && io_addr_i == ADDR_CAP_LO && !icr_top && !capture)
        |=> $stable(s.cap))
        else $error("capture register took a write");
    // high location write only reaches the latch
    hi_latch_a: assert property (
        (io_wr_i && io_addr_i == ADDR_CNT_HI && !tick)
        |=> s.temp == $past(io_wdata_i) && $stable(s.count))
        else $error("high write reached the counter");
    // low read hands out low byte and latches high byte
    lo_latch_a: assert property (
        lo_read_s |=> s.temp == $past(s.count[15:8])
        && io_rdata_o == $past(s.count[7:0]))
        else $error("low read did not latch high byte");
    // wrap from the maximum always raises overflow
    ovf_set_a: assert property (
        (tick && !mode.dual && s.count == TOP_MAX && !cnt_wr)
        |=> s.ovf_flag)
        else $error("overflow flag not set at wrap");
    // capture low read loads the latch
    cap_read_a: assert property (
        (io_rd_i && io_addr_i == ADDR_CAP_LO && !io_wr_i)
        |=> s.temp == $past(s.cap[15:8]))
        else $error("capture low read did not latch");
    // compare high read is direct and leaves the latch alone
    cmp_direct_a: assert property (
        (io_rd_i && io_addr_i == ADDR_CMPA_HI && !io_wr_i)
        |=> io_rdata_o == $past(s.cmpa[15:8]) && $stable(s.temp))
        else $error("compare read went through latch");
    // no rising edge, no time stamp
    edge_only_a: assert property (
        (s.ctrl_b[CTRLB_EDGE_BIT] && !(s.filt && !s.filt_prev)
         && !(io_wr_i && io_addr_i == ADDR_CAP_LO)) |=> $stable(s.cap))
        else $error("capture without selected edge");
endmodule : tcc_timer16
`default_nettype wire

/* File: rtl/tcc_pkg.sv */
// Operation
// - clock select zero stops the counter
// - sixteen-bit counter steps one up or down
// - clear forces every counter bit to zero
// - bottom at zero, top at sequence top
// - counter seen as two byte locations
// - high-byte locations reach only the latch
// - low read latches high, low write loads
// - counter accessible with or without tick
// - cpu write beats clear and count
// - waveform mode sets sequence and top
// - overflow flag per mode, interrupt source
// - capture from pin or comparator output
// - capture only on the selected edge
// - capture copies counter, sets flag together
// - enabled flag requests irq, ack clears
// - writing one clears flag, zero keeps
// - capture read low first, high from latch
// - capture writable only when it is top
// - top is fixed value, compare a, capture
// - compare reads bypass the latch
package tcc_pkg;
    // i/o locations of the byte-wide register port
    localparam logic [3:0] ADDR_CNT_LO = 4'h0;
    localparam logic [3:0] ADDR_CNT_HI = 4'h1;
    localparam logic [3:0] ADDR_CAP_LO = 4'h2;
    localparam logic [3:0] ADDR_CAP_HI = 4'h3;
    localparam logic [3:0] ADDR_CMPA_LO = 4'h4;
    localparam logic [3:0] ADDR_CMPA_HI = 4'h5;
    localparam logic [3:0] ADDR_CMPB_LO = 4'h6;
    localparam logic [3:0] ADDR_CMPB_HI = 4'h7;
    localparam logic [3:0] ADDR_CTRL_A = 4'h8;
    localparam logic [3:0] ADDR_CTRL_B = 4'h9;
    localparam logic [3:0] ADDR_FLAGS = 4'hA;
    localparam logic [3:0] ADDR_IRQ_EN = 4'hB;
    // field positions
    localparam int CTRLA_WGM_LSB = 0;
    localparam int CTRLB_CS_LSB = 0;
    localparam int CTRLB_WGM_LSB = 3;
    localparam int CTRLB_EDGE_BIT = 6;
    localparam int CTRLB_NC_BIT = 7;
    localparam int FLAG_CAP_BIT = 0;
    localparam int FLAG_OVF_BIT = 1;
    // reset values and fixed counts
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_SYSCLK = 3'h1;
    localparam logic [15:0] TOP_MAX = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam int NC_SAMPLES = 4;
    // counting direction, one-hot
    typedef enum logic [1:0] {
        DIR_UP = 2'b01,
        DIR_DOWN = 2'b10
    } tcc_dir_t;
    // where the top value comes from, one-hot
    typedef enum logic [5:0] {
        SRC_MAX = 6'b000001,
        SRC_8 = 6'b000010,
        SRC_9 = 6'b000100,
        SRC_10 = 6'b001000,
        SRC_CMPA = 6'b010000,
        SRC_CAP = 6'b100000
    } tcc_top_t;
    // decoded waveform mode
    typedef struct packed {
        tcc_top_t src;
        logic dual;
        logic ovf_top;
    } tcc_mode_t;
    // waveform mode table
    function automatic tcc_mode_t tcc_decode(input logic [3:0] wgm);
        tcc_mode_t m;
        m = '{SRC_MAX, 1'b0, 1'b0};
        case (wgm)
            4'h1: m = '{SRC_8, 1'b1, 1'b0};
            4'h2: m = '{SRC_9, 1'b1, 1'b0};
            4'h3: m = '{SRC_10, 1'b1, 1'b0};
            4'h4: m = '{SRC_CMPA, 1'b0, 1'b0};
            4'h5: m = '{SRC_8, 1'b0, 1'b1};
            4'h6: m = '{SRC_9, 1'b0, 1'b1};
            4'h7: m = '{SRC_10, 1'b0, 1'b1};
            4'h8: m = '{SRC_CAP, 1'b1, 1'b0};
            4'h9: m = '{SRC_CMPA, 1'b1, 1'b0};
            4'hA: m = '{SRC_CAP, 1'b1, 1'b0};
            4'hB: m = '{SRC_CMPA, 1'b1, 1'b0};
            4'hC: m = '{SRC_CAP, 1'b0, 1'b0};
            4'hE: m = '{SRC_CAP, 1'b0, 1'b1};
            4'hF: m = '{SRC_CMPA, 1'b0, 1'b1};
            default: m = '{SRC_MAX, 1'b0, 1'b0};
        endcase
        return m;
    endfunction : tcc_decode
endpackage : tcc_pkg

/* File: dv/tcc_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
// cpu side of the byte-wide register port
module tcc_cpu_model (
    input wire logic clk_i,
    input wire logic [7:0] io_rdata_i,
    output logic [3:0] io_addr_o,
    output logic io_wr_o,
    output logic io_rd_o,
    output logic [7:0] io_wdata_o
);
    // idle bus from time zero
    initial begin
        io_addr_o = 4'hF;
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        io_wdata_o = 8'h00;
    end

    // one byte access, strobe held over one rising edge
    // accesses run strictly one after another, never interleaved
    task automatic access(input logic rd, input logic [3:0] a,
            input logic [7:0] d, output logic [7:0] q);
        @(negedge clk_i);
        io_addr_o = a;
        io_wdata_o = d;
        io_rd_o = rd;
        io_wr_o = !rd;
        @(negedge clk_i);
        io_rd_o = 1'b0;
        io_wr_o = 1'b0;
        // released lines flip so stale values cannot pass for good ones
        io_addr_o = ~a;
        io_wdata_o = ~d;
        // read data is registered, so it is valid one cycle on
        q = io_rdata_i;
    endtask : access
endmodule : tcc_cpu_model
`default_nettype wire

/* File: dv/timer16_counter_capture_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module timer16_counter_capture_tb;
    import tcc_pkg::*;
    logic clk_i = 1'b0; // 200 MHz system clock
    logic reset_i = 1'b1; // held for ten cycles
    logic [3:0] addr;
    logic wstb;
    logic rstb;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic tick = 1'b0; // count enable pulses
    logic pin = 1'b0;
    logic cmp = 1'b0;
    logic sel = 1'b0;
    logic cack = 1'b0;
    logic oack = 1'b0;
    logic cirq;
    logic oirq;
    logic top;
    logic bot;
    // bench model of the timer state, plain integers
    int m_cnt = 0, m_lat = 0, m_cap = 0, m_cmpa = 0;
    int m_mode = 0, m_cs = 0, m_flg = 0;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h00007C55;
    // modes with a fixed or compare-a top, and their tops
    logic [3:0] tm [7] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h4};
    logic [15:0] tv [7] = '{16'h00FF, 16'h01FF, 16'h03FF, 16'h00FF,
        16'h01FF, 16'h03FF, 16'h0003};

    tcc_timer16 u_tcc_timer16 (
        .clk_i(clk_i), .reset_i(reset_i), .io_addr_i(addr),
        .io_wr_i(wstb), .io_rd_i(rstb), .io_wdata_i(wdata),
        .io_rdata_o(rdata), .timer_tick_i(tick), .capture_pin_i(pin),
        .comparator_output_i(cmp), .comparator_sel_i(sel),
        .capture_ack_i(cack), .overflow_ack_i(oack),
        .capture_irq_o(cirq), .overflow_irq_o(oirq),
        .top_o(top), .bottom_o(bot)
    );

    tcc_cpu_model u_tcc_cpu_model (
        .clk_i(clk_i), .io_rdata_i(rdata), .io_addr_o(addr),
        .io_wr_o(wstb), .io_rd_o(rstb), .io_wdata_o(wdata)
    );

    // free-running clock
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    // hang guard, far above the few hundred cycles needed
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end

    // counts and verdict
    task automatic test_done();
        $display("checks %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    // compare one result with the model
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // xorshift source, fixed start
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // byte write, model follows
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_tcc_cpu_model.access(1'b0, a, d, q);
        case (a)
            ADDR_CNT_LO: m_cnt = (m_lat << 8) | d;
            ADDR_CMPA_LO: m_cmpa = (m_lat << 8) | d;
            ADDR_CAP_LO: begin
                // only accepted while the capture value is the top
                if (m_mode inside {8, 10, 12, 14}) begin
                    m_cap = (m_lat << 8) | d;
                end
            end
            ADDR_CNT_HI, ADDR_CAP_HI: m_lat = d;
            ADDR_CMPA_HI, ADDR_CMPB_HI: m_lat = d;
            ADDR_FLAGS: m_flg = m_flg & ~d;
            default: ;
        endcase
    endtask : wr

    // byte read, compared with the model
    task automatic rd(input logic [3:0] a);
        logic [7:0] q;
        int e;
        u_tcc_cpu_model.access(1'b1, a, 8'h00, q);
        case (a)
            ADDR_CNT_LO: begin
                e = m_cnt & 255;
                m_lat = m_cnt >> 8;
            end
            ADDR_CAP_LO: begin
                e = m_cap & 255;
                m_lat = m_cap >> 8;
            end
            ADDR_CNT_HI, ADDR_CAP_HI: e = m_lat;
            ADDR_CMPA_LO: e = m_cmpa & 255;
            ADDR_CMPA_HI: e = m_cmpa >> 8;
            ADDR_FLAGS: e = m_flg;
            default: e = 0; // unmapped reads as zero
        endcase
        check({8'h00, q}, 16'(e));
    endtask : rd

    // word access, high byte written first, low byte read first
    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        wr(a + 4'h1, v[15:8]);
        wr(a, v[7:0]);
    endtask : wr16

    task automatic rd16(input logic [3:0] a);
        rd(a);
        rd(a + 4'h1);
    endtask : rd16

    // mode and clock select; rising capture edge, filter off
    task automatic mode(input logic [3:0] w, input logic [2:0] cs);
        wr(ADDR_CTRL_A, {6'h00, w[1:0]});
        wr(ADDR_CTRL_B, {2'b01, 1'b0, w[3:2], cs});
        m_mode = w;
        m_cs = cs;
    endtask : mode

    // count enable pulses; model steps only while a clock is selected
    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge clk_i);
            tick = 1'b1;
            @(negedge clk_i);
            tick = 1'b0;
            if (m_cs != 0) begin
                if (m_cnt == ((m_mode == 4) ? m_cmpa : 65535)) begin
                    m_flg = m_flg | ((m_cnt == 65535) ? 2 : 0);
                    m_cnt = 0;
                end else begin
                    m_cnt = m_cnt + 1;
                end
            end
        end
    endtask : ticks

    // move a capture source, then allow sync and edge delay
    task automatic src(input int k, input logic v);
        @(negedge clk_i);
        if (k == 1) begin
            cmp = v;
        end else begin
            pin = v;
        end
        repeat (8) @(negedge clk_i);
    endtask : src

    // main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        reset_i = 1'b0;
        check({15'h0000, bot}, 16'h0001);
        check({15'h0000, top}, 16'h0000);
        rd16(ADDR_CNT_LO);
        rd16(ADDR_CAP_LO);
        rd(ADDR_FLAGS);
        rd(4'hE);
        $display("reset test done");
        // stopped counter still reachable; high write alone changes nothing
        for (int i = 0; i < 4; i++) begin
            wr16(ADDR_CNT_LO, 16'(rnd()));
            ticks(3);
            rd16(ADDR_CNT_LO);
        end
        wr(ADDR_CNT_HI, 8'hA5);
        rd16(ADDR_CNT_LO);
        $display("access test done");
        // ticked counting, write against a tick, overflow, compare clear
        mode(4'h0, 3'h2);
        wr16(ADDR_CNT_LO, 16'(rnd()));
        ticks(int'(rnd() % 20) + 1);
        rd16(ADDR_CNT_LO);
        wr(ADDR_CNT_HI, 8'h12); // normal mode, no special case
        tick = 1'b1;
        wr(ADDR_CNT_LO, 8'h34);
        tick = 1'b0;
        rd16(ADDR_CNT_LO);
        wr(ADDR_FLAGS, 8'h03);
        wr(ADDR_IRQ_EN, 8'h02);
        wr16(ADDR_CNT_LO, 16'hFFFE);
        ticks(1);
        check({15'h0000, top}, 16'h0001);
        ticks(1);
        check({15'h0000, bot}, 16'h0001);
        check({15'h0000, oirq}, 16'h0001);
        rd(ADDR_FLAGS);
        @(negedge clk_i);
        oack = 1'b1;
        @(negedge clk_i);
        oack = 1'b0;
        m_flg = m_flg & 1;
        rd(ADDR_FLAGS);
        mode(4'h4, 3'h2);
        wr16(ADDR_CMPA_LO, 16'h0003);
        wr16(ADDR_CNT_LO, 16'h0000);
        ticks(6);
        rd16(ADDR_CNT_LO);
        $display("count test done");
        // top per mode, one below it is not top
        for (int i = 0; i < 7; i++) begin
            mode(tm[i], 3'h0);
            wr16(ADDR_CNT_LO, tv[i]);
            check({15'h0000, top}, 16'h0001);
            wr16(ADDR_CNT_LO, tv[i] - 16'h0001);
            check({15'h0000, top}, 16'h0000);
        end
        mode(4'hC, 3'h0);
        wr16(ADDR_CAP_LO, 16'h0789);
        wr16(ADDR_CNT_LO, 16'h0789);
        check({15'h0000, top}, 16'h0001);
        rd16(ADDR_CAP_LO);
        mode(4'h0, 3'h0);
        wr16(ADDR_CAP_LO, 16'h1111);
        rd16(ADDR_CAP_LO);
        $display("top test done");
        // shared high byte reused; compare reads bypass it
        wr16(ADDR_CMPA_LO, 16'h0456);
        wr(ADDR_CNT_LO, 8'h78);
        wr(ADDR_CNT_HI, 8'h99);
        rd(ADDR_CMPA_HI);
        rd(ADDR_CMPA_LO);
        rd16(ADDR_CNT_LO);
        $display("latch test done");
        // capture from pin, then from comparator
        wr(ADDR_IRQ_EN, 8'h01);
        for (int k = 0; k < 2; k++) begin
            sel = (k == 1);
            wr16(ADDR_CNT_LO, 16'(rnd()));
            src(k, 1'b1);
            m_cap = m_cnt;
            m_flg = m_flg | 1;
            check({15'h0000, cirq}, 16'h0001);
            rd16(ADDR_CAP_LO);
            wr(ADDR_FLAGS, 8'h00);
            rd(ADDR_FLAGS);
            if (k == 0) begin
                wr(ADDR_FLAGS, 8'h01);
            end else begin
                @(negedge clk_i);
                cack = 1'b1;
                @(negedge clk_i);
                cack = 1'b0;
                m_flg = m_flg & 2;
            end
            check({15'h0000, cirq}, 16'h0000);
            src(k, 1'b0);
            rd(ADDR_FLAGS);
        end
        $display("capture test done");
        test_done();
    end
endmodule : timer16_counter_capture_tb
`default_nettype wire
